//--- bench/adog_sva.sv
// assertions on the ports of the option gating register bank
`timescale 1ns/1ps
`default_nettype none
module adog_sva #(
    parameter int OPTION = 1
) (
    // clock and reset
    input wire logic                     ref_clk_i,
    input wire logic                     sys_rst_i,
    // register access
    input wire adog_pkg::adog_req_s      req_i,
    input wire logic [7:0]               rdata_o,
    input wire logic                     ack_o,
    // gated outputs
    input wire adog_pkg::adog_wake_cfg_s wake_cfg_o,
    input wire logic [15:0]              conversion_request_bit_o,
    input wire adog_pkg::adog_curr_mon_s curr_mon_o
);
    import adog_pkg::*;
    logic rq;
    logic hit;
    logic cut;
    assign rq = req_i.rd | req_i.wr;
    assign hit = rq & req_i.addr[9];
    assign cut = (OPTION != 1);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    hit_ack_a: assert property (hit |=> ack_o)
        else $error("hit not acknowledged");
    miss_quiet_a: assert property (rq && !req_i.addr[9] |=> !ack_o)
        else $error("request outside window acknowledged");
    ack_cause_a: assert property (ack_o |-> $past(hit))
        else $error("acknowledge without request");
    cm_read_a: assert property (cut && hit && req_i.rd
        && req_i.addr[7:0] == ADOG_OFS_CURR_MON |=> rdata_o == 8'h00)
        else $error("current monitor reads nonzero");
    cm_off_a: assert property (cut |-> curr_mon_o == '0)
        else $error("current monitor active");
    chan_gate_a: assert property (cut |-> (conversion_request_bit_o & 16'h0380) == 16'h0000)
        else $error("absent channel requested");
    bit_thirteen_a: assert property (!conversion_request_bit_o[13])
        else $error("request bit 13 set");
    wake_gate_a: assert property (cut |-> wake_cfg_o.wake_enable[5:4] == 2'h0
        && wake_cfg_o.digital_select[5:4] == 2'h0)
        else $error("absent wake input configured");
    level_gate_a: assert property (cut && hit && req_i.rd
        && req_i.addr[7:0] == ADOG_OFS_LEVEL_STATUS |=> rdata_o[7:4] == 4'h0)
        else $error("absent input level visible");
    cover property (hit && req_i.rd);
    cover property (hit && req_i.wr);
    cover property (rq && !req_i.addr[9]);
endmodule // adog_sva
`default_nettype wire

//--- bench/adog_top_tb.sv
// self-checking bench for the gating bank built in both options
`timescale 1ns/1ps
`default_nettype none
module adog_top_tb;
    import adog_pkg::*;
    logic           clk;
    logic           rst;
    adog_req_s      req;
    logic [7:0]     rdata;
    logic           ack;
    logic [5:0]     pins;
    logic [5:0]     cause;
    logic           forced;
    logic           bus;
    adog_wake_cfg_s wcfg;
    logic [15:0]    done;
    adog_result_s   res;
    logic [15:0]    creq;
    adog_curr_mon_s cmon;
    logic [7:0]     rd;
    logic [7:0]     rd_full;
    logic [7:0]     rdata_full;
    logic           ack_full;
    adog_wake_cfg_s wcfg_full;
    logic [15:0]    creq_full;
    adog_curr_mon_s cmon_full;
    int             bad_count = 0;
    int             tests_run = 0;
    int             cycles = 0;

    adog_top #(.OPTION(2)) dut (
        .ref_clk_i(clk), .sys_rst_i(rst), .req_i(req), .rdata_o(rdata), .ack_o(ack),
        .wake_input_pins_i(pins), .wake_input_cause_flag_i(cause),
        .forced_wake_cause_i(forced), .bus_wake_cause_i(bus), .wake_cfg_o(wcfg),
        .conv_done_i(done), .result_i(res), .conversion_request_bit_o(creq),
        .curr_mon_o(cmon)
    );

    // full build on the same stimulus, for the option-1 side of the gating
    adog_top #(.OPTION(1)) dut_full (
        .ref_clk_i(clk), .sys_rst_i(rst), .req_i(req),
        .rdata_o(rdata_full), .ack_o(ack_full),
        .wake_input_pins_i(pins), .wake_input_cause_flag_i(cause),
        .forced_wake_cause_i(forced), .bus_wake_cause_i(bus), .wake_cfg_o(wcfg_full),
        .conv_done_i(done), .result_i(res), .conversion_request_bit_o(creq_full),
        .curr_mon_o(cmon_full)
    );

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one access; ack expected only inside the two windows
    task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge clk) #1 req = '{!w, w, a, d};
        @(posedge clk) #1 req = '0;
        chk("ack", {15'h0, a[9]}, {15'h0, ack});
        chk("full ack", {15'h0, a[9]}, {15'h0, ack_full});
        rd = rdata;
        rd_full = rdata_full;
    endtask

    task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
        acc(1'b0, a, 8'h00);
        chk($sformatf("read %h", a), {8'h0, exp}, {8'h0, rd});
    endtask

    task automatic t_reset();
        chk("outputs", 16'h0000, creq | {2'h0, wcfg} | {11'h0, cmon});
        chk("full outputs", 16'h0000, creq_full | {2'h0, wcfg_full} | {11'h0, cmon_full});
        rchk(10'h212, 8'h00);
        $display("done reset");
    endtask

    task automatic t_window();
        rchk(10'h208, 8'h0f);
        chk("full level", 16'h003f, {8'h0, rd_full});
        rchk(10'h308, 8'h0f);
        acc(1'b0, 10'h108, 8'h00);
        acc(1'b1, 10'h2f0, 8'hff);
        rchk(10'h2f0, 8'h00);
        $display("done window");
    endtask

    task automatic t_config();
        acc(1'b1, 10'h23c, 8'h00);
        acc(1'b1, 10'h33c, 8'h8f);
        chk("monitor", 16'h0000, {11'h0, cmon});
        chk("full monitor", 16'h001f, {11'h0, cmon_full});
        rchk(10'h23c, 8'h00);
        chk("full monitor read", 16'h008f, {8'h0, rd_full});
        acc(1'b1, 10'h212, 8'hff);
        acc(1'b1, 10'h209, 8'h0f);
        acc(1'b1, 10'h309, 8'hff);
        chk("wake cfg", {2'h0, 6'h0f, 6'h0f, 2'h3}, {2'h0, wcfg});
        chk("full wake cfg", {2'h0, 6'h3f, 6'h3f, 2'h3}, {2'h0, wcfg_full});
        rchk(10'h212, 8'hcf);
        rchk(10'h209, 8'h0f);
        $display("done config");
    endtask

    task automatic t_conv();
        acc(1'b1, 10'h282, 8'hfd);
        acc(1'b1, 10'h282, 8'hff);
        acc(1'b1, 10'h283, 8'hff);
        chk("requests", 16'hdc7f, creq);
        chk("full requests", 16'hdfff, creq_full);
        @(posedge clk) #1 done = 16'hffff;
        @(posedge clk) #1 done = 16'h0000;
        chk("requests cleared", 16'h0000, creq);
        rchk(10'h284, 8'hdc);
        rchk(10'h285, 8'h7f);
        $display("done conversion");
    endtask

    task automatic t_result();
        @(posedge clk) #1 res = '{1'b1, 4'h3, 10'h2a5};
        @(posedge clk) #1 res = '{1'b1, 4'h9, 10'h3ff};
        @(posedge clk) #1 res = '{1'b1, 4'h7, 10'h3ff};
        @(posedge clk) #1 res = '0;
        rchk(10'h28c, 8'ha9);
        rchk(10'h28d, 8'h40);
        rchk(10'h298, 8'h00);
        rchk(10'h299, 8'h00);
        rchk(10'h294, 8'h00);
        $display("done result");
    endtask

    task automatic t_cause();
        @(posedge clk) #1 {forced, bus, cause} = 8'hff;
        @(posedge clk) #1 {forced, bus, cause} = 8'h00;
        rchk(10'h214, 8'hcf);
        chk("full cause", 16'h00ff, {8'h0, rd_full});
        rchk(10'h314, 8'h00);
        $display("done cause");
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            wrap_up();
        end
    end

    initial begin
        rst = 1'b1;
        req = '0;
        res = '0;
        pins = 6'h3f;
        {cause, forced, bus, done} = '0;
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        t_reset();
        t_window();
        t_config();
        t_conv();
        t_result();
        t_cause();
        wrap_up();
    end
endmodule // adog_top_tb

bind adog_top adog_sva #(.OPTION(OPTION)) u_sva (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .rdata_o(rdata_o),
    .ack_o(ack_o), .wake_cfg_o(wake_cfg_o),
    .conversion_request_bit_o(conversion_request_bit_o), .curr_mon_o(curr_mon_o)
);
`default_nettype wire

//--- logic/adog_pkg.sv
// package of offsets, fields and carriers for the analog die option gating bank
`default_nettype none
package adog_pkg;
    // ------------------------------------------------------------------
    // address windows on the die-to-die interface
    // ------------------------------------------------------------------
    localparam logic [9:0] ADOG_BASE_BLOCKING    = 10'h200;
    localparam logic [9:0] ADOG_BASE_NONBLOCKING = 10'h300;
    localparam logic [1:0] ADOG_WIN_BLOCKING     = 2'h2;
    localparam logic [1:0] ADOG_WIN_NONBLOCKING  = 2'h3;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADOG_OFS_LEVEL_STATUS = 8'h08;
    localparam logic [7:0] ADOG_OFS_INPUT_CTRL   = 8'h09;
    localparam logic [7:0] ADOG_OFS_WAKE_ENABLE  = 8'h12;
    localparam logic [7:0] ADOG_OFS_WAKE_CAUSE   = 8'h14;
    localparam logic [7:0] ADOG_OFS_CURR_MON     = 8'h3c;
    localparam logic [7:0] ADOG_OFS_CONV_REQ_HI  = 8'h82;
    localparam logic [7:0] ADOG_OFS_CONV_REQ_LO  = 8'h83;
    localparam logic [7:0] ADOG_OFS_CONV_DONE_HI = 8'h84;
    localparam logic [7:0] ADOG_OFS_CONV_DONE_LO = 8'h85;
    localparam logic [7:0] ADOG_OFS_RESULT_FIRST = 8'h8c;
    localparam logic [7:0] ADOG_OFS_RESULT_LAST  = 8'h99;
    // channel n high byte sits at this base plus twice n
    localparam logic [7:0] ADOG_OFS_RESULT_BASE  = 8'h86;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int ADOG_NUM_WAKE          = 6;
    localparam int ADOG_NUM_CHAN          = 16;
    localparam int ADOG_CHAN_CURRENT      = 9;
    localparam int ADOG_CHAN_WAKE_FIRST   = 3;
    localparam int ADOG_CHAN_RESERVED     = 13;
    localparam int ADOG_CM_ENABLE_BIT     = 7;
    localparam int ADOG_CM_OFFSET_BIT     = 3;
    localparam int ADOG_CAUSE_FORCED_BIT  = 7;
    localparam int ADOG_CAUSE_BUS_BIT     = 6;
    localparam logic [7:0] ADOG_RST_BYTE  = 8'h00;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [9:0] addr;
        logic [7:0] wdata;
    } adog_req_s;

    typedef struct packed {
        logic       enable;
        logic       offset_mode;
        logic [2:0] gain_select;
    } adog_curr_mon_s;

    typedef struct packed {
        logic [5:0] digital_select;
        logic [5:0] wake_enable;
        logic [1:0] cyclic_sense_select;
    } adog_wake_cfg_s;

    typedef struct packed {
        logic       valid;
        logic [3:0] chan;
        logic [9:0] value;
    } adog_result_s;
endpackage : adog_pkg
`default_nettype wire

//--- logic/adog_top.sv
// register bank of the analog die with option-dependent feature gating
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module adog_top #(
    parameter int OPTION = 1
) (
    // clock and reset
    input  wire logic                     ref_clk_i,
    input  wire logic                     sys_rst_i,
    // die-to-die register access
    input  wire adog_pkg::adog_req_s      req_i,
    output var  logic [7:0]               rdata_o,
    output var  logic                     ack_o,
    // wake inputs and wake events
    input  wire logic [5:0]               wake_input_pins_i,
    input  wire logic [5:0]               wake_input_cause_flag_i,
    input  wire logic                     forced_wake_cause_i,
    input  wire logic                     bus_wake_cause_i,
    output var  adog_pkg::adog_wake_cfg_s wake_cfg_o,
    // converter
    input  wire logic [15:0]              conv_done_i,
    input  wire adog_pkg::adog_result_s   result_i,
    output var  logic [15:0]              conversion_request_bit_o,
    // current monitor
    output var  adog_pkg::adog_curr_mon_s curr_mon_o
);
    import adog_pkg::*;

    // ------------------------------------------------------------------
    // option masks
    // ------------------------------------------------------------------
    // any OPTION other than 1 builds the reduced die
    localparam bit         HAS_CURRENT = (OPTION == 1);
    localparam logic [5:0] WAKE_MASK   = HAS_CURRENT ? 6'h3f : 6'h0f;
    localparam logic [15:0] CHAN_MASK  = build_chan_mask();

    // channel 13 has no converter input; wake input x feeds channel 3+x
    function automatic logic [15:0] build_chan_mask();
        logic [15:0] m;
        m = 16'hffff;
        m[ADOG_CHAN_RESERVED] = 1'b0;
        if (!HAS_CURRENT) begin
            m[ADOG_CHAN_CURRENT] = 1'b0;
        end
        for (int i = 0; i < ADOG_NUM_WAKE; i++) begin
            if (!WAKE_MASK[i]) begin
                m[ADOG_CHAN_WAKE_FIRST + i] = 1'b0;
            end
        end
        return m;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]          rdata;
        logic                ack;
        logic [5:0]          level;
        adog_wake_cfg_s      wake;
        logic [7:0]          cause;
        adog_curr_mon_s      cm;
        logic [15:0]         req;
        logic [15:0]         done;
        logic [15:0][9:0]    result;
    } adog_state_s;

    adog_state_s state_q;
    adog_state_s state_d;

    logic       hit;
    logic       rd_hit;
    logic       wr_hit;
    logic [7:0] ofs;
    logic [7:0] rsel;
    logic [3:0] rchan;
    logic [7:0] cause_clr;
    logic [15:0] done_clr;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d   = state_q;
        ofs       = req_i.addr[7:0];
        // both windows map onto the same registers
        hit       = (req_i.addr[9:8] == ADOG_WIN_BLOCKING)
                 || (req_i.addr[9:8] == ADOG_WIN_NONBLOCKING);
        rd_hit    = req_i.rd && hit;
        wr_hit    = req_i.wr && hit;
        // unmapped offsets in a window read zero and ignore writes
        rsel      = 8'h00;
        rchan     = 4'h0;
        cause_clr = 8'h00;
        done_clr  = 16'h0000;

        // address decode for reads
        if (ofs == ADOG_OFS_LEVEL_STATUS) begin
            rsel = {2'h0, state_q.level};
        end else if (ofs == ADOG_OFS_INPUT_CTRL) begin
            rsel = {2'h0, state_q.wake.digital_select};
        end else if (ofs == ADOG_OFS_WAKE_ENABLE) begin
            rsel = {state_q.wake.cyclic_sense_select, state_q.wake.wake_enable};
        end else if (ofs == ADOG_OFS_WAKE_CAUSE) begin
            // reading the cause register clears every cause bit
            rsel = state_q.cause;
            if (rd_hit) begin
                cause_clr = 8'hff;
            end
        end else if (ofs == ADOG_OFS_CURR_MON) begin
            rsel = {state_q.cm.enable, 3'h0, state_q.cm.offset_mode,
                    state_q.cm.gain_select};
        end else if (ofs == ADOG_OFS_CONV_REQ_HI) begin
            rsel = state_q.req[15:8];
        end else if (ofs == ADOG_OFS_CONV_REQ_LO) begin
            rsel = state_q.req[7:0];
        end else if (ofs == ADOG_OFS_CONV_DONE_HI) begin
            rsel = state_q.done[15:8];
        end else if (ofs == ADOG_OFS_CONV_DONE_LO) begin
            rsel = state_q.done[7:0];
        end else if (ofs >= ADOG_OFS_RESULT_FIRST && ofs <= ADOG_OFS_RESULT_LAST) begin
            // two bytes per channel: even offset high byte, odd offset low byte
            rchan = 4'((ofs - ADOG_OFS_RESULT_BASE) >> 1);
            if (!CHAN_MASK[rchan]) begin
                rsel = 8'h00;
            end else if (ofs[0] == 1'b0) begin
                rsel = state_q.result[rchan][9:2];
            end else begin
                rsel = {state_q.result[rchan][1:0], 6'h00};
            end
        end

        // every hit in either window is acknowledged one cycle later
        state_d.ack   = rd_hit || wr_hit;
        // read data holds until the next read
        state_d.rdata = rd_hit ? rsel : state_q.rdata;

        // writes: bits of absent functions are dropped
        if (wr_hit) begin
            if (ofs == ADOG_OFS_INPUT_CTRL) begin
                state_d.wake.digital_select = req_i.wdata[5:0] & WAKE_MASK;
            end else if (ofs == ADOG_OFS_WAKE_ENABLE) begin
                state_d.wake.cyclic_sense_select = req_i.wdata[7:6];
                state_d.wake.wake_enable = req_i.wdata[5:0] & WAKE_MASK;
            end else if (ofs == ADOG_OFS_CURR_MON) begin
                // the reduced build keeps the monitor register at its zero reset
                if (HAS_CURRENT) begin
                    state_d.cm.enable      = req_i.wdata[ADOG_CM_ENABLE_BIT];
                    state_d.cm.offset_mode = req_i.wdata[ADOG_CM_OFFSET_BIT];
                    state_d.cm.gain_select = req_i.wdata[2:0];
                end
            end else if (ofs == ADOG_OFS_CONV_REQ_HI) begin
                // a fresh request clears the stale done flag of its channel
                state_d.req[15:8] = req_i.wdata & CHAN_MASK[15:8];
                done_clr[15:8] = req_i.wdata;
            end else if (ofs == ADOG_OFS_CONV_REQ_LO) begin
                state_d.req[7:0] = req_i.wdata & CHAN_MASK[7:0];
                done_clr[7:0] = req_i.wdata;
            end
        end

        // level status: absent inputs have no digital path
        // level status lags the pins by one clock
        state_d.level = wake_input_pins_i & WAKE_MASK;

        // sticky wake causes, cleared by a read; a new event wins
        state_d.cause = (state_q.cause & ~cause_clr)
                      | {forced_wake_cause_i, bus_wake_cause_i,
                         wake_input_cause_flag_i & WAKE_MASK};

        // conversion done flags, cleared by a new request; done wins
        state_d.done = ((state_q.done & ~done_clr) | conv_done_i) & CHAN_MASK;
        for (int c = 0; c < ADOG_NUM_CHAN; c++) begin
            if (CHAN_MASK[c] && conv_done_i[c]) begin
                state_d.req[c] = 1'b0;
            end
        end

        // result capture for offered channels only
        if (result_i.valid && CHAN_MASK[result_i.chan]) begin
            state_d.result[result_i.chan] = result_i.value;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rdata_o                  = state_q.rdata;
    assign ack_o                    = state_q.ack;
    assign wake_cfg_o               = state_q.wake;
    assign conversion_request_bit_o = state_q.req;
    assign curr_mon_o               = state_q.cm;

endmodule // adog_top
`default_nettype wire
